// >>> rtl/apmc_defs.svh
// Offsets, field positions and reset values of the port clock configuration block.
`ifndef APMC_DEFS_SVH
`define APMC_DEFS_SVH

`define APMC_OFS_CFG_A 8'h13
`define APMC_OFS_CFG_B 8'h14
`define APMC_RST_CFG_A 8'h02
`define APMC_RST_CFG_B 8'h48

`define APMC_BIT_ROLE 7
`define APMC_BIT_CUSTOM 6
`define APMC_BIT_LOOP_OFF 5
`define APMC_BIT_GATE 4
`define APMC_BIT_FAMILY 3
`define APMC_REFCODE_MSB 2
`define APMC_REFCODE_LSB 0
`define APMC_RATE_MSB 7
`define APMC_RATE_LSB 4
`define APMC_RATIO_MSB 3
`define APMC_RATIO_LSB 0

`define APMC_RATE_LAST 4'h8
`define APMC_RATIO_LAST 4'hC

`endif

// >>> rtl/apmc_pkg.sv
// Types shared by the port clock configuration block.
`default_nettype none
package apmc_pkg;

	typedef enum logic [1:0] {
		APMC_ROOT_LOOP = 2'b00,
		APMC_ROOT_BCLK = 2'b01,
		APMC_ROOT_REF = 2'b10
	} apmc_root_t;

	typedef struct packed {
		logic [7:0] cfg_a;
		logic [7:0] cfg_b;
		logic [7:0] rdata;
		logic bclk_s1;
		logic bclk_s2;
		logic fs_s1;
		logic fs_s2;
		logic ref_s1;
		logic ref_s2;
		logic bclk_o;
		logic fs_o;
		logic oe;
		logic loop_en;
		apmc_root_t root_sel;
		logic root_lvl;
		logic rates_used;
		logic run;
		logic [31:0] inc;
		logic [31:0] ref_hz;
		logic [11:0] ratio;
	} apmc_top_st_t;

	typedef struct packed {
		logic ref_d1;
		logic [32:0] acc;
		logic bclk;
		logic fs;
		logic [11:0] cnt;
	} apmc_gen_st_t;

endpackage
`default_nettype wire

// >>> rtl/apmc_gen_if.sv
// Carrier between the configuration logic and the master clock generator.
`default_nettype none
interface apmc_gen_if;
	logic run;
	logic ref_level;
	logic [31:0] inc;
	logic [31:0] ref_hz;
	logic [11:0] ratio;
	logic bclk;
	logic fs;

	modport cfg (output run, output ref_level, output inc, output ref_hz, output ratio,
		input bclk, input fs);
	modport gen (input run, input ref_level, input inc, input ref_hz, input ratio,
		output bclk, output fs);
endinterface
`default_nettype wire

// >>> rtl/apmc_clkgen.sv
// Master bit clock and frame sync generator paced by reference clock edges.
`default_nettype none
module apmc_clkgen (
	input wire logic mclk,
	input wire logic rst_n,
	apmc_gen_if.gen g
);
	apmc_pkg::apmc_gen_st_t s_q;
	apmc_pkg::apmc_gen_st_t s_d;
	logic [32:0] sum;

	// Each reference edge adds twice the bit clock rate; one wrap of the reference rate is
	// one half period. Only one toggle per reference edge is possible, so a bit clock above
	// half the reference rate saturates there.
	always_comb begin
		s_d = s_q;
		sum = s_q.acc + {1'b0, g.inc};
		s_d.ref_d1 = g.ref_level;
		if (!g.run) begin
			s_d.acc = 33'h000000000;
			s_d.bclk = 1'b0;
			s_d.fs = 1'b0;
			s_d.cnt = 12'h000;
		end else if (g.ref_level && !s_q.ref_d1) begin
			if (sum >= {1'b0, g.ref_hz}) begin
				s_d.acc = (sum - {1'b0, g.ref_hz} >= {1'b0, g.ref_hz}) ?
					33'h000000000 : sum - {1'b0, g.ref_hz};
				s_d.bclk = !s_q.bclk;
				if (s_q.bclk) begin
					// Frame sync changes with the falling bit clock, one bit period per frame.
					s_d.cnt = (s_q.cnt >= g.ratio - 12'h001) ? 12'h000 : s_q.cnt + 12'h001;
					s_d.fs = (s_q.cnt >= g.ratio - 12'h001);
				end
			end else begin
				s_d.acc = sum;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign g.bclk = s_q.bclk;
	assign g.fs = s_q.fs;
endmodule
`default_nettype wire

// >>> rtl/apmc_top.sv
// Serial audio port master/slave clock configuration registers and clock control.
`default_nettype none
`include "apmc_defs.svh"
module apmc_top (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic reference_by_ratio_mode,
	input wire logic [2:0] reference_ratio_code,
	input wire logic loop_off_root_source,
	input wire logic custom_loop_enable,
	input wire logic [31:0] custom_bclk_hz,
	input wire logic ref_clk_in,
	input wire logic bclk_in,
	output logic bclk_out,
	output logic bclk_oe,
	input wire logic frame_sync_in,
	output logic frame_sync_out,
	output logic frame_sync_oe,
	output logic loop_enable,
	output logic [1:0] root_select,
	output logic root_level,
	output logic rates_in_use
);
	apmc_pkg::apmc_top_st_t s_q;
	apmc_pkg::apmc_top_st_t s_d;
	apmc_gen_if g ();

	// ---------------------------------------------------------------
	// Rate tables
	// ---------------------------------------------------------------
	function automatic logic [31:0] rate_hz(input logic [3:0] code, input logic fam);
		logic [31:0] r;
		r = 32'h00000000;
		unique case (code)
			4'h0: r = fam ? 32'h00001CB6 : 32'h00001F40;
			4'h1: r = fam ? 32'h0000396C : 32'h00003E80;
			4'h2: r = fam ? 32'h00005622 : 32'h00005DC0;
			4'h3: r = fam ? 32'h000072D8 : 32'h00007D00;
			4'h4: r = fam ? 32'h0000AC44 : 32'h0000BB80;
			4'h5: r = fam ? 32'h00015888 : 32'h00017700;
			4'h6: r = fam ? 32'h0002B110 : 32'h0002EE00;
			4'h7: r = fam ? 32'h00056220 : 32'h0005DC00;
			4'h8: r = fam ? 32'h000AC440 : 32'h000BB800;
			default: r = 32'h00000000;
		endcase
		return r;
	endfunction

	function automatic logic [11:0] ratio_val(input logic [3:0] code);
		logic [11:0] r;
		r = 12'h000;
		unique case (code)
			4'h0: r = 12'h010;
			4'h1: r = 12'h018;
			4'h2: r = 12'h020;
			4'h3: r = 12'h030;
			4'h4: r = 12'h040;
			4'h5: r = 12'h060;
			4'h6: r = 12'h080;
			4'h7: r = 12'h0C0;
			4'h8: r = 12'h100;
			4'h9: r = 12'h180;
			4'hA: r = 12'h200;
			4'hB: r = 12'h400;
			4'hC: r = 12'h800;
			default: r = 12'h000;
		endcase
		return r;
	endfunction

	function automatic logic [31:0] ref_code_hz(input logic [2:0] code);
		logic [31:0] r;
		r = 32'h00000000;
		unique case (code)
			3'h0: r = 32'h00B71B00;
			3'h1: r = 32'h00BB8000;
			3'h2: r = 32'h00C65D40;
			3'h3: r = 32'h00F42400;
			3'h4: r = 32'h0124F800;
			3'h5: r = 32'h012C4B00;
			3'h6: r = 32'h016E3600;
			3'h7: r = 32'h01770000;
		endcase
		return r;
	endfunction

	function automatic logic [11:0] ref_mult(input logic [2:0] code);
		logic [11:0] r;
		r = 12'h000;
		unique case (code)
			3'h0: r = 12'h040;
			3'h1: r = 12'h100;
			3'h2: r = 12'h180;
			3'h3: r = 12'h200;
			3'h4: r = 12'h300;
			3'h5: r = 12'h400;
			3'h6: r = 12'h600;
			3'h7: r = 12'h900;
		endcase
		return r;
	endfunction

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	logic master;
	logic custom;
	logic [3:0] rate_code;
	logic [3:0] ratio_code;
	logic [31:0] fs_hz;
	logic [63:0] prod;
	logic [63:0] ref_prod;
	logic codes_ok;

	always_comb begin
		s_d = s_q;
		master = s_q.cfg_a[`APMC_BIT_ROLE];
		custom = s_q.cfg_a[`APMC_BIT_CUSTOM];
		rate_code = s_q.cfg_b[`APMC_RATE_MSB:`APMC_RATE_LSB];
		ratio_code = s_q.cfg_b[`APMC_RATIO_MSB:`APMC_RATIO_LSB];
		fs_hz = rate_hz(rate_code, s_q.cfg_a[`APMC_BIT_FAMILY]);
		prod = {32'h00000000, fs_hz} * {52'h0000000000000, ratio_val(ratio_code)} * 64'h2;
		ref_prod = {32'h00000000, fs_hz} * {52'h0000000000000, ref_mult(reference_ratio_code)};
		// Reserved codes are left to software to avoid; the generator simply stays idle.
		codes_ok = (rate_code <= `APMC_RATE_LAST) && (ratio_code <= `APMC_RATIO_LAST);

		if (reg_wr && reg_addr == `APMC_OFS_CFG_A) begin
			s_d.cfg_a = reg_wdata;
		end
		if (reg_wr && reg_addr == `APMC_OFS_CFG_B) begin
			s_d.cfg_b = reg_wdata;
		end
		if (reg_rd) begin
			unique case (reg_addr)
				`APMC_OFS_CFG_A: s_d.rdata = s_q.cfg_a;
				`APMC_OFS_CFG_B: s_d.rdata = s_q.cfg_b;
				default: s_d.rdata = 8'h00;
			endcase
		end

		s_d.bclk_s1 = bclk_in;
		s_d.bclk_s2 = s_q.bclk_s1;
		s_d.fs_s1 = frame_sync_in;
		s_d.fs_s2 = s_q.fs_s1;
		s_d.ref_s1 = ref_clk_in;
		s_d.ref_s2 = s_q.ref_s1;

		// Outside master and custom modes rate and ratio come from the bus, so the programmed fields go unused.
		s_d.rates_used = master || custom;
		s_d.ratio = ratio_val(ratio_code);
		s_d.inc = custom ? custom_bclk_hz : prod[31:0];
		s_d.ref_hz = reference_by_ratio_mode ? ref_prod[31:0] :
			ref_code_hz(s_q.cfg_a[`APMC_REFCODE_MSB:`APMC_REFCODE_LSB]);
		// The gate only stops the generator in master mode.
		s_d.run = master && !s_q.cfg_a[`APMC_BIT_GATE] && codes_ok;
		s_d.oe = master;
		s_d.bclk_o = g.bclk;
		s_d.fs_o = g.fs;

		s_d.loop_en = custom ? custom_loop_enable : !s_q.cfg_a[`APMC_BIT_LOOP_OFF];
		if (!master && !custom && s_q.cfg_a[`APMC_BIT_LOOP_OFF]) begin
			s_d.root_sel = loop_off_root_source ?
				apmc_pkg::APMC_ROOT_REF : apmc_pkg::APMC_ROOT_BCLK;
		end else begin
			s_d.root_sel = apmc_pkg::APMC_ROOT_LOOP;
		end
		unique case (s_q.root_sel)
			apmc_pkg::APMC_ROOT_BCLK: s_d.root_lvl = s_q.bclk_s2;
			apmc_pkg::APMC_ROOT_REF: s_d.root_lvl = s_q.ref_s2;
			default: s_d.root_lvl = 1'b0;
		endcase
	end

	// ---------------------------------------------------------------
	// State register
	// ---------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			s_q <= '0;
			s_q.cfg_a <= `APMC_RST_CFG_A;
			s_q.cfg_b <= `APMC_RST_CFG_B;
			s_q.loop_en <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign g.run = s_q.run;
	assign g.ref_level = s_q.ref_s2;
	assign g.inc = s_q.inc;
	assign g.ref_hz = s_q.ref_hz;
	assign g.ratio = s_q.ratio;

	apmc_clkgen u_gen (
		.mclk(mclk),
		.rst_n(rst_n),
		.g(g)
	);

	assign reg_rdata = s_q.rdata;
	assign bclk_out = s_q.bclk_o;
	assign bclk_oe = s_q.oe;
	assign frame_sync_out = s_q.fs_o;
	assign frame_sync_oe = s_q.oe;
	assign loop_enable = s_q.loop_en;
	assign root_select = s_q.root_sel;
	assign root_level = s_q.root_lvl;
	assign rates_in_use = s_q.rates_used;
endmodule
`default_nettype wire

// >>> verification/apmc_checker.sv
// Port-level assertions for the port clock configuration block.
`default_nettype none
module apmc_checker (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic loop_off_root_source,
	input wire logic custom_loop_enable,
	input wire logic bclk_out,
	input wire logic bclk_oe,
	input wire logic frame_sync_out,
	input wire logic frame_sync_oe,
	input wire logic loop_enable,
	input wire logic [1:0] root_select,
	input wire logic rates_in_use,
	input wire logic root_level,
	input wire logic ref_clk_in
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	sequence wr_a;
		reg_wr && reg_addr == 8'h13;
	endsequence
	sequence quiet;
		!bclk_out && !frame_sync_out;
	endsequence
	role_oe_a: assert property (wr_a |-> ##2 bclk_oe == $past(reg_wdata[7], 2))
		else $error("enable not per role");
	oe_pair_a: assert property (frame_sync_oe == bclk_oe)
		else $error("enables differ");
	loop_ctl_a: assert property (wr_a |-> ##2 loop_enable ==
		($past(reg_wdata[6], 2) ? $past(custom_loop_enable) : !$past(reg_wdata[5], 2)))
		else $error("loop enable wrong");
	gate_stop_a: assert property (wr_a ##0 reg_wdata[4] |-> ##4 quiet [*4])
		else $error("gated clocks run");
	slave_quiet_a: assert property (!bclk_oe [*3] |-> quiet)
		else $error("slave drives clocks");
	ignore_rates_a: assert property (wr_a |-> ##2 rates_in_use ==
		($past(reg_wdata[7], 2) | $past(reg_wdata[6], 2))) else $error("rate use wrong");
	root_sel_a: assert property (wr_a |-> ##2 root_select ==
		((!$past(reg_wdata[7], 2) && !$past(reg_wdata[6], 2) && $past(reg_wdata[5], 2)) ?
		{$past(loop_off_root_source), !$past(loop_off_root_source)} : 2'h0))
		else $error("root select wrong");
	fs_edge_a: assert property ($rose(frame_sync_out) |-> $fell(bclk_out))
		else $error("frame sync off bit clock fall");
	root_lvl_a: assert property (root_select == 2'h2 |=>
		root_level == $past(ref_clk_in, 3)) else $error("root level not reference");
	root_idle_a: assert property (root_select == 2'h0 |=> !root_level)
		else $error("root level not idle");
endmodule
bind apmc_top apmc_checker chk (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
	.loop_off_root_source, .custom_loop_enable, .bclk_out, .bclk_oe, .frame_sync_out,
	.frame_sync_oe, .loop_enable, .root_select, .rates_in_use, .root_level, .ref_clk_in);
`default_nettype wire

// >>> verification/apmc_host.sv
// Host on the serial audio link: owns the lines in slave mode, monitors frames in master mode.
`default_nettype none
module apmc_host (
	input wire logic ref_clk,
	input wire logic bclk_out,
	input wire logic bclk_oe,
	input wire logic frame_sync_out,
	input wire logic frame_sync_oe,
	output logic bclk_line,
	output logic fs_line,
	output int bits_q,
	output int edges_q,
	output int frames_q
);
	timeunit 1ns;
	timeprecision 1ns;
	int bcnt = 0;
	int ecnt = 0;
	int b0 = 0;
	int e0 = 0;
	logic fs_prev = 1'b0;
	initial begin
		bits_q = 0;
		edges_q = 0;
		frames_q = 0;
	end
	// With no frames to send the host holds both lines still while it owns them.
	assign bclk_line = bclk_oe ? bclk_out : 1'b0;
	assign fs_line = frame_sync_oe ? frame_sync_out : 1'b0;
	always @(posedge ref_clk) ecnt <= ecnt + 1;
	// Frame sync is taken on the rising bit clock, as a receiver would take it.
	always @(posedge bclk_out) begin
		bcnt <= bcnt + 1;
		fs_prev <= frame_sync_out;
		if (frame_sync_out && !fs_prev) begin
			bits_q <= bcnt - b0;
			b0 <= bcnt;
			edges_q <= ecnt - e0;
			e0 <= ecnt;
			frames_q <= frames_q + 1;
		end
	end
endmodule
`default_nettype wire

// >>> verification/apmc_bench.sv
// Self-checking bench for the port clock configuration block.
`default_nettype none
module apmc_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, by_ratio = 1'b0;
	logic root_src = 1'b0, cust_loop = 1'b1, ref_clk = 1'b0;
	logic [2:0] ref_code = 3'h0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic bclk_out, bclk_oe, bclk_ln, fs_out, fs_oe, fs_ln, loop_en, rates;
	logic [1:0] root_sel;
	int hbits, hedges, frames, f0, d, fs, n_errors = 0, total_checks = 0, cycles = 0;
	int fsk [9] = '{8000, 16000, 24000, 32000, 48000, 96000, 192000, 384000, 768000};
	int refhz [8] = '{12000000, 12288000, 13000000, 16000000, 19200000, 19680000,
		24000000, 24576000};
	int ratio [13] = '{16, 24, 32, 48, 64, 96, 128, 192, 256, 384, 512, 1024, 2048};
	always #5 mclk = ~mclk;
	// The reference oscillator runs free; the half nanosecond offset keeps its edges off
	// every system clock edge, so the sampled level is never a race.
	initial begin
		#0.5;
		forever #11 ref_clk = ~ref_clk;
	end
	apmc_top dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.reference_by_ratio_mode(by_ratio), .reference_ratio_code(ref_code),
		.loop_off_root_source(root_src), .custom_loop_enable(cust_loop),
		.custom_bclk_hz(32'h002EE000), .ref_clk_in(ref_clk), .bclk_in(bclk_ln),
		.bclk_out(bclk_out), .bclk_oe(bclk_oe), .frame_sync_in(fs_ln),
		.frame_sync_out(fs_out), .frame_sync_oe(fs_oe), .loop_enable(loop_en),
		.root_select(root_sel), .root_level(), .rates_in_use(rates));
	apmc_host host (.ref_clk(ref_clk), .bclk_out(bclk_out), .bclk_oe(bclk_oe),
		.frame_sync_out(fs_out), .frame_sync_oe(fs_oe), .bclk_line(bclk_ln),
		.fs_line(fs_ln), .bits_q(hbits), .edges_q(hedges), .frames_q(frames));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: saw %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		reg_addr = a;
		reg_wdata = v;
		reg_wr = 1'b1;
		@(posedge mclk);
		#1 reg_wr = 1'b0;
		// An idle edge between calls keeps the strobe from being lowered and raised at once.
		@(posedge mclk);
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge mclk);
		#1 reg_rd = 1'b0;
		chk(reg_rdata, e);
		@(posedge mclk);
		#1;
	endtask
	// Gating first restarts the generator cleanly, so the second frame after it is whole.
	task automatic run(input logic [7:0] a, input logic [7:0] b);
		wr(8'h13, a | 8'h10);
		wr(8'h14, b);
		repeat (4) @(posedge mclk);
		#1 chk(bclk_out | fs_out, 1'b0);
		wr(8'h13, a);
		f0 = frames;
		wait (frames >= f0 + 2);
		@(posedge mclk);
		#1;
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 90000) begin
			n_errors++;
			wrap_up();
		end
	end
	initial begin
		repeat (10) @(posedge mclk);
		#1 rst_n = 1'b1;
		rd(8'h13, 8'h02);
		rd(8'h14, 8'h48);
		wr(8'h15, 8'hFF);
		rd(8'h15, 8'h00);
		root_src = 1'b1;
		wr(8'h13, 8'h20);
		repeat (2) @(posedge mclk);
		#1 chk(root_sel, 2'h2);
		chk(loop_en, 1'b0);
		chk(rates, 1'b0);
		chk(bclk_oe | fs_oe, 1'b0);
		wr(8'h13, 8'h60);
		repeat (2) @(posedge mclk);
		#1 chk(loop_en, 1'b1);
		chk(rates, 1'b1);
		rd(8'h13, 8'h60);
		$display("register test done");
		for (int i = 0; i < 9; i++) begin
			fs = i[0] ? fsk[i] / 160 * 147 : fsk[i];
			run({4'h8, i[0], 3'h7 - i[2:0]}, {i[3:0], 4'h0}); // Legal codes only.
			d = hedges - refhz[7 - i % 8] / fs;
			chk(hbits, 16);
			chk(d >= -2 && d <= 2, 1'b1);
		end
		chk(bclk_oe & fs_oe, 1'b1);
		$display("rate test done");
		by_ratio = 1'b1;
		for (int i = 0; i < 13; i++) begin
			run(8'h80, {4'h8, i[3:0]});
			chk(hbits, ratio[i]);
			if (i == 0)
				chk(hedges, 64);
		end
		ref_code = 3'h1;
		run(8'h80, 8'h80);
		chk(hedges, 256);
		ref_code = 3'h0;
		run(8'hC0, 8'h80);
		chk(hbits, 16);
		chk(hedges, 512);
		$display("ratio test done");
		wrap_up();
	end
endmodule
`default_nettype wire
